// ---- hdl/capture_pkg.sv ----
// Constants and types shared by the three-channel capture unit
package capture_pkg;
  localparam int          CH_COUNT          = 3;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ENABLE_FLAGS  = 8'h92;
  localparam logic [7:0]  IDX_EDGE_SELECT   = 8'h93;
  localparam logic [7:0]  IDX_FILTER        = 8'h94;
  localparam logic [7:0]  IDX_INT_ENABLE    = 8'ha8;
  localparam logic [7:0]  IDX_IRQ_STATUS    = 8'ha9;
  localparam logic [7:0]  IDX_IRQ_MASK      = 8'haa;
  localparam logic [7:0]  IDX_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0]  IDX_TIMER_MODE    = 8'hc9;
  localparam logic [7:0]  IDX_COUNTER_LOW   = 8'hcc;
  localparam logic [7:0]  IDX_COUNTER_HIGH  = 8'hcd;
  localparam logic [2:0][7:0] IDX_RESULT_LOW  = {8'hed, 8'he6, 8'he4};
  localparam logic [2:0][7:0] IDX_RESULT_HIGH = {8'hee, 8'he7, 8'he5};
  // Field positions
  localparam int          POS_CH_ENABLE     = 4;
  localparam int          POS_CH_FLAG       = 0;
  localparam int          POS_FILTER_ENABLE = 4;
  localparam int          EDGE_SEL_W        = 2;
  localparam int          POS_TIMER_RUN     = 2;
  localparam int          POS_COMPARE_SEL   = 0;
  localparam int          POS_RELOAD_EN     = 7;
  localparam int          POS_PRESCALE      = 4;
  localparam int          PRESCALE_W        = 3;
  localparam int          POS_AUTO_CLEAR    = 3;
  localparam int          POS_CAPTURE_IE    = 7;
  localparam int          POS_GLOBAL_IE     = 0;
  // Writable bits; the rest read as zero
  localparam logic [7:0]  MASK_ENABLE_FLAGS = 8'h77;
  localparam logic [7:0]  MASK_EDGE_SELECT  = 8'h3f;
  localparam logic [7:0]  MASK_FILTER       = 8'h70;
  localparam logic [7:0]  MASK_INT_ENABLE   = 8'h81;
  localparam logic [7:0]  MASK_IRQ          = 8'h07;
  localparam logic [7:0]  MASK_TIMER_CTRL   = 8'h05;
  localparam logic [7:0]  MASK_TIMER_MODE   = 8'hf8;
  // Reset values
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RESET    = 8'h07;
  localparam logic [15:0] COUNTER_CLEAR     = 16'h0000;
  // Timing
  localparam int          FILTER_CYCLES     = 4;
  localparam logic [1:0]  FILTER_LAST       = 2'(FILTER_CYCLES - 1);
  localparam logic [9:0]  PRESCALE_MIN      = 10'h004;
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_RSVD = 2'b11
  } edge_sel_t;
endpackage

// ---- hdl/timer2_input_capture.sv ----
// Three-channel input capture unit with its 16-bit timer, APB register slave
// Operation
// R1: Captures happen only while the compare/reload select and the reload enable bits are both clear.
// R2: Three independent channels, each fed from its own pin (Schmitt stage sits in the pad).
// R3: With its filter enabled a channel ignores pulses shorter than four clock cycles.
// R4: Each channel has its own edge detector and all sample the one common counter.
// R5: Edge select 00 falling, 01 rising, 10 both, 11 reserved and never triggers.
// R6: A channel reacts only while its enable bit (bits 6..4 for channels 2..0) is set.
// R7: A selected edge copies the counter high and low bytes into that channel's result pair.
// R8: The counter keeps running through a capture unless auto-clear is on.
// R9: A qualifying edge sets the channel flag at bit n of the enable/flag register.
// R10: The shared interrupt is raised while a flag is set and both interrupt enables are set; the code also requires that flag's interrupt mask bit to be set.
// R11: Software reads the three flags to learn which channel captured.
// R12: Hardware never clears a flag; software clears it by writing.
// R13: With auto-clear on, the counter goes to zero right after the capture latches it.
// R14: Each result is 16 bits in separate readable and writable low and high byte registers.
// R15: Clearing the run bit halts and holds the count; setting it lets it advance.
// R16: The counter advances once per 4 to 512 clocks, chosen in powers of two by a 3-bit field.
// R17: Each capture pin passes two flip-flops before filtering and edge detection.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module timer2_input_capture
  import capture_pkg::*;
(
  // Clock and reset
  input  logic                        i_sys_clk,
  input  logic                        i_rst_b,
  // APB slave
  input  logic                        i_psel,
  input  logic                        i_penable,
  input  logic                        i_pwrite,
  input  logic [capture_pkg::ADDR_W-1:0] i_paddr,
  input  logic [capture_pkg::DATA_W-1:0] i_pwdata,
  input  logic [3:0]                  i_pstrb,
  output logic [capture_pkg::DATA_W-1:0] o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // Capture pins
  input  logic                        i_capture_pin_0,
  input  logic                        i_capture_pin_1,
  input  logic                        i_capture_pin_2,
  // Interrupt
  output logic                        o_capture_irq
);
  import capture_pkg::*;

  logic [7:0]          enable_flags;
  logic [7:0]          edge_select;
  logic [7:0]          filter_control;
  logic [7:0]          int_enable;
  logic [7:0]          irq_status;
  logic [7:0]          irq_mask;
  logic [7:0]          timer_control;
  logic [7:0]          timer_mode;
  logic [15:0]         counter;
  logic [8:0]          div_cnt;
  logic [9:0]          div_len;
  logic                tick;
  logic                capture_mode;
  logic                auto_clear;
  logic [2:0]          pin_raw;
  logic [2:0]          capture_evt;
  logic [2:0][15:0]    result;
  logic [7:0]          idx;
  logic                addr_ok;
  logic                hit;
  logic [7:0]          rd_byte;
  logic                access;
  logic                wr_en;
  logic                rd_done;
  logic [7:0]          wbyte;
  logic [2:0]          irq_pending;

  // Bus decode
  assign idx     = i_paddr[9:2];
  assign addr_ok = (i_paddr[ADDR_W-1:10] == 2'h0) && (i_paddr[1:0] == 2'h0);
  assign access  = i_psel && i_penable;
  assign wr_en   = access && o_pready && i_pwrite && i_pstrb[0] && hit;
  assign rd_done = access && o_pready && !i_pwrite;
  assign wbyte   = i_pwdata[7:0];

  // Capture qualifiers
  assign capture_mode = !timer_control[POS_COMPARE_SEL] && !timer_mode[POS_RELOAD_EN]; // R1
  assign auto_clear   = timer_mode[POS_AUTO_CLEAR];
  assign pin_raw      = {i_capture_pin_2, i_capture_pin_1, i_capture_pin_0}; // R2

  // Register read mux
  always_comb begin
    hit     = 1'b1;
    rd_byte = REG_RESET;
    if (!addr_ok) begin
      hit = 1'b0;
    end else if (idx == IDX_ENABLE_FLAGS) begin
      rd_byte = enable_flags;
    end else if (idx == IDX_EDGE_SELECT) begin
      rd_byte = edge_select;
    end else if (idx == IDX_FILTER) begin
      rd_byte = filter_control;
    end else if (idx == IDX_INT_ENABLE) begin
      rd_byte = int_enable;
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_byte = irq_status;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_byte = irq_mask;
    end else if (idx == IDX_TIMER_CONTROL) begin
      rd_byte = timer_control;
    end else if (idx == IDX_TIMER_MODE) begin
      rd_byte = timer_mode;
    end else if (idx == IDX_COUNTER_LOW) begin
      rd_byte = counter[7:0];
    end else if (idx == IDX_COUNTER_HIGH) begin
      rd_byte = counter[15:8];
    end else if (idx == IDX_RESULT_LOW[0]) begin
      rd_byte = result[0][7:0]; // R14
    end else if (idx == IDX_RESULT_HIGH[0]) begin
      rd_byte = result[0][15:8]; // R14
    end else if (idx == IDX_RESULT_LOW[1]) begin
      rd_byte = result[1][7:0];
    end else if (idx == IDX_RESULT_HIGH[1]) begin
      rd_byte = result[1][15:8];
    end else if (idx == IDX_RESULT_LOW[2]) begin
      rd_byte = result[2][7:0];
    end else if (idx == IDX_RESULT_HIGH[2]) begin
      rd_byte = result[2][15:8];
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state so read data comes from a flip-flop
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= access && !o_pready;
    end
  end

  // Read data loaded in the first access cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_prdata <= {DATA_W{1'b0}};
    end else if (access && !o_pready) begin
      o_prdata <= {24'h000000, rd_byte};
    end
  end

  // Error with the same timing as the data
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pslverr <= 1'b0;
    end else if (access && !o_pready) begin
      o_pslverr <= !hit;
    end
  end

  // Edge select
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      edge_select <= REG_RESET;
    end else if (wr_en && idx == IDX_EDGE_SELECT) begin
      edge_select <= wbyte & MASK_EDGE_SELECT;
    end
  end

  // Filter enables
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      filter_control <= REG_RESET;
    end else if (wr_en && idx == IDX_FILTER) begin
      filter_control <= wbyte & MASK_FILTER;
    end
  end

  // Interrupt enables
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      int_enable <= REG_RESET;
    end else if (wr_en && idx == IDX_INT_ENABLE) begin
      int_enable <= wbyte & MASK_INT_ENABLE;
    end
  end

  // Interrupt mask
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_en && idx == IDX_IRQ_MASK) begin
      irq_mask <= wbyte & MASK_IRQ;
    end
  end

  // Timer control
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      timer_control <= REG_RESET;
    end else if (wr_en && idx == IDX_TIMER_CONTROL) begin
      timer_control <= wbyte & MASK_TIMER_CTRL;
    end
  end

  // Timer mode
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      timer_mode <= REG_RESET;
    end else if (wr_en && idx == IDX_TIMER_MODE) begin
      timer_mode <= wbyte & MASK_TIMER_MODE;
    end
  end

  // Enables and flags; a capture in the clearing cycle keeps its flag
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      enable_flags <= REG_RESET;
    end else begin
      if (wr_en && idx == IDX_ENABLE_FLAGS) begin
        enable_flags <= (wbyte & MASK_ENABLE_FLAGS) | {5'h00, capture_evt}; // R12
      end else begin
        enable_flags <= enable_flags | {5'h00, capture_evt}; // R9
      end
    end
  end

  // Sticky event log, cleared by reading it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      irq_status <= REG_RESET;
    end else if (rd_done && addr_ok && idx == IDX_IRQ_STATUS) begin
      irq_status <= {5'h00, capture_evt};
    end else begin
      irq_status <= irq_status | {5'h00, capture_evt};
    end
  end

  // Flags that survive the mask
  assign irq_pending = enable_flags[POS_CH_FLAG +: CH_COUNT] & irq_mask[2:0]; // R10

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_capture_irq <= 1'b0;
    end else begin
      o_capture_irq <= int_enable[POS_CAPTURE_IE] && int_enable[POS_GLOBAL_IE] && |irq_pending; // R10
    end
  end

  // Prescaler: divide by 4 << field
  assign div_len = PRESCALE_MIN << timer_mode[POS_PRESCALE +: PRESCALE_W]; // R16
  // At or past the end, so a shorter divide never wraps the divider
  assign tick    = timer_control[POS_TIMER_RUN] && (div_cnt >= 9'(div_len - 10'h001));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      div_cnt <= 9'h000;
    end else if (tick) begin
      div_cnt <= 9'h000;
    end else if (timer_control[POS_TIMER_RUN]) begin
      div_cnt <= div_cnt + 9'h001; // R15
    end
  end

  // Counter: software write, then auto-clear, then advance
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      counter <= COUNTER_CLEAR;
    end else if (wr_en && idx == IDX_COUNTER_LOW) begin
      counter[7:0] <= wbyte;
    end else if (wr_en && idx == IDX_COUNTER_HIGH) begin
      counter[15:8] <= wbyte;
    end else if (auto_clear && |capture_evt) begin
      counter <= COUNTER_CLEAR; // R13
    end else if (tick) begin
      counter <= counter + 16'h0001; // R8 R15
    end
  end

  // Per-channel capture path
  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++) begin : g_ch
      logic       sync_a;
      logic       sync_b;
      logic       level;
      logic       level_d;
      logic [1:0] stable_cnt;
      edge_sel_t  sel;
      logic       rise;
      logic       fall;
      logic       hit_edge;
      logic       filter_on;
      logic       ch_enable;

      // Two-flop synchroniser
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          sync_a <= 1'b0;
          sync_b <= 1'b0;
        end else begin
          sync_a <= pin_raw[ch]; // R17
          sync_b <= sync_a; // R17
        end
      end

      // With its filter on, level follows the pin only after it differs for four cycles
      assign filter_on = filter_control[POS_FILTER_ENABLE + ch]; // R3

      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          level      <= 1'b0;
          stable_cnt <= 2'h0;
        end else begin
          if (!filter_on) begin
            level      <= sync_b;
            stable_cnt <= 2'h0;
          end else if (sync_b == level) begin
            stable_cnt <= 2'h0;
          end else if (stable_cnt == FILTER_LAST) begin
            level      <= sync_b; // R3
            stable_cnt <= 2'h0;
          end else begin
            stable_cnt <= stable_cnt + 2'h1; // R3
          end
        end
      end

      // Delayed level for the edge detector
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          level_d <= 1'b0;
        end else begin
          level_d <= level;
        end
      end

      // Edge detector on the filtered level
      assign sel  = edge_sel_t'(edge_select[EDGE_SEL_W*ch +: EDGE_SEL_W]);
      assign rise = level && !level_d; // R4
      assign fall = !level && level_d; // R4

      always_comb begin
        unique case (sel)
          EDGE_FALL: hit_edge = fall; // R5
          EDGE_RISE: hit_edge = rise; // R5
          EDGE_BOTH: hit_edge = rise || fall; // R5
          EDGE_RSVD: hit_edge = 1'b0; // R5
        endcase
      end

      assign ch_enable       = enable_flags[POS_CH_ENABLE + ch]; // R6
      assign capture_evt[ch] = hit_edge && capture_mode && ch_enable; // R1 R6

      // Result low byte; a capture wins over a software write
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          result[ch][7:0] <= COUNTER_CLEAR[7:0];
        end else if (capture_evt[ch]) begin
          result[ch][7:0] <= counter[7:0]; // R4 R7
        end else if (wr_en && idx == IDX_RESULT_LOW[ch]) begin
          result[ch][7:0] <= wbyte; // R14
        end
      end

      // Result high byte; a capture wins over a software write
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          result[ch][15:8] <= COUNTER_CLEAR[15:8];
        end else if (capture_evt[ch]) begin
          result[ch][15:8] <= counter[15:8]; // R4 R7
        end else if (wr_en && idx == IDX_RESULT_HIGH[ch]) begin
          result[ch][15:8] <= wbyte; // R14
        end
      end
    end
  endgenerate

endmodule

// ---- testbench/capture_pins_model.sv ----
// Drives the three capture input pins
`timescale 1ns/1ps
module capture_pins_model (
  input  wire logic       i_sys_clk,
  output logic      [2:0] o_pins
);
  initial o_pins = 3'h0;
  // One dedicated pin per channel
  task automatic drive(input int ch, input logic v);
    @(posedge i_sys_clk);
    o_pins[ch] <= v;
  endtask
  task automatic pulse(input int ch, input int w);
    drive(ch, 1'b1);
    repeat (w - 1) @(posedge i_sys_clk);
    drive(ch, 1'b0);
  endtask
endmodule

// ---- testbench/tb_timer2_input_capture.sv ----
// Register-level tests of the three-channel capture unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_timer2_input_capture;
  import capture_pkg::*;
  localparam logic [7:0] REGS [15] = '{IDX_RESULT_LOW[0], IDX_RESULT_HIGH[0], IDX_RESULT_LOW[1],
    IDX_RESULT_HIGH[1], IDX_RESULT_LOW[2], IDX_RESULT_HIGH[2], IDX_ENABLE_FLAGS, IDX_EDGE_SELECT,
    IDX_FILTER, IDX_INT_ENABLE, IDX_IRQ_STATUS, IDX_TIMER_CONTROL, IDX_TIMER_MODE,
    IDX_COUNTER_LOW, IDX_COUNTER_HIGH};
  logic              sys_clk;
  logic              rst_b;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [2:0]        pins;
  logic              irq;
  logic [DATA_W-1:0] rd;
  logic              err;
  logic [7:0]        cnt;
  logic              en;
  logic              hit;
  int                sel;
  int                error_cnt;
  int                compares;
  timer2_input_capture DUT (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_capture_pin_0(pins[0]), .i_capture_pin_1(pins[1]), .i_capture_pin_2(pins[2]),
    .o_capture_irq(irq));
  capture_pins_model pm (.i_sys_clk(sys_clk), .o_pins(pins));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(n, {24'h0, e}, rd)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial begin
    #(40 * 20000);
    error_cnt++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    idle(20);
    rst_b <= 1'b1;
    foreach (REGS[i]) rdc("reset", REGS[i], REG_RESET);
    rdc("irq_mask", IDX_IRQ_MASK, IRQ_MASK_RESET);
    apb(1'b0, 8'h00, 8'h00);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 6; i++) begin
      wr(REGS[i], 8'(8'ha0 + i));
      rdc("result_rw", REGS[i], 8'(8'ha0 + i));
    end
    wr(IDX_EDGE_SELECT, 8'hff);
    rdc("reserved", IDX_EDGE_SELECT, MASK_EDGE_SELECT);
    wr(IDX_INT_ENABLE, 8'h81);
    for (int ch = 0; ch < 3; ch++)
      for (int m = 0; m < 7; m++)
        for (int v = 1; v >= 0; v--) begin
          sel = m < 4 ? m : 2;
          en = m != 4;
          hit = en && m < 5 && (sel == 2 || sel == v);
          wr(IDX_TIMER_CONTROL, m == 5 ? 8'h01 : 8'h00);
          wr(IDX_TIMER_MODE, m == 6 ? 8'h80 : 8'h00);
          wr(IDX_COUNTER_LOW, 8'(16 * ch + 2 * m + v));
          wr(IDX_COUNTER_HIGH, 8'(8'hc0 + ch));
          wr(IDX_RESULT_LOW[ch], 8'h00);
          wr(IDX_RESULT_HIGH[ch], 8'h00);
          wr(IDX_EDGE_SELECT, 8'(sel << (2 * ch)));
          wr(IDX_ENABLE_FLAGS, 8'(en) << (4 + ch));
          pm.drive(ch, 1'(v));
          idle(16);
          rdc("flags", IDX_ENABLE_FLAGS, (8'(en) << (4 + ch)) | (8'(hit) << ch));
          `CHK("irq", hit, irq)
          rdc("res_l", IDX_RESULT_LOW[ch], hit ? 8'(16 * ch + 2 * m + v) : 8'h00);
          rdc("res_h", IDX_RESULT_HIGH[ch], hit ? 8'(8'hc0 + ch) : 8'h00);
          rdc("status", IDX_IRQ_STATUS, 8'(hit) << ch);
          rdc("status_clr", IDX_IRQ_STATUS, 8'h00);
        end
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_TIMER_MODE, 8'h00);
    wr(IDX_EDGE_SELECT, 8'h01);
    wr(IDX_FILTER, 8'h10);
    for (int w = 3; w <= 5; w += 2) begin
      wr(IDX_ENABLE_FLAGS, 8'h10);
      pm.pulse(0, w);
      idle(20);
      rdc("filter", IDX_ENABLE_FLAGS, w > 4 ? 8'h11 : 8'h10);
    end
    wr(IDX_FILTER, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(IDX_COUNTER_LOW, 8'h00);
      wr(IDX_COUNTER_HIGH, 8'h00);
      wr(IDX_TIMER_MODE, 8'(p << 4));
      wr(IDX_TIMER_CONTROL, 8'h04);
      idle(396);
      wr(IDX_TIMER_CONTROL, 8'h00);
      apb(1'b0, IDX_COUNTER_LOW, 8'h00);
      cnt = rd[7:0];
      `CHK("count", 1'b1, cnt inside {[8'(97 >> p):8'(103 >> p)]})
      idle(40);
      rdc("hold", IDX_COUNTER_LOW, cnt);
    end
    wr(IDX_COUNTER_HIGH, 8'h40);
    wr(IDX_TIMER_MODE, 8'h08);
    wr(IDX_TIMER_CONTROL, 8'h04);
    wr(IDX_ENABLE_FLAGS, 8'h10);
    pm.drive(0, 1'b1);
    idle(16);
    wr(IDX_TIMER_CONTROL, 8'h00);
    rdc("auto_clear", IDX_COUNTER_HIGH, COUNTER_CLEAR[15:8]);
    rdc("cap_run", IDX_RESULT_HIGH[0], 8'h40);
    wr(IDX_IRQ_MASK, 8'h00);
    idle(2);
    `CHK("irq_mask", 1'b0, irq)
    wr(IDX_IRQ_MASK, 8'h07);
    idle(2);
    `CHK("irq_unmask", 1'b1, irq)
    wr(IDX_INT_ENABLE, 8'h80);
    idle(2);
    `CHK("irq_global", 1'b0, irq)
    finish_test();
  end
endmodule
bind timer2_input_capture timer2_input_capture_properties chk (.i_sys_clk, .i_rst_b, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_capture_pin_0,
  .i_capture_pin_1, .i_capture_pin_2, .o_capture_irq);

// ---- testbench/timer2_input_capture_properties.sv ----
// Port-level properties of the capture unit
`timescale 1ns/1ps
module timer2_input_capture_properties
  import capture_pkg::*;
(
  input logic                          i_sys_clk,
  input logic                          i_rst_b,
  input logic                          i_psel,
  input logic                          i_penable,
  input logic                          i_pwrite,
  input logic [capture_pkg::ADDR_W-1:0] i_paddr,
  input logic [capture_pkg::DATA_W-1:0] o_prdata,
  input logic                          o_pready,
  input logic                          o_pslverr,
  input logic                          i_capture_pin_0,
  input logic                          i_capture_pin_1,
  input logic                          i_capture_pin_2,
  input logic                          o_capture_irq
);
  logic [3:0] pin_age;
  logic [3:0] wr_age;
  logic [2:0] pins_d;
  logic [7:0] idx;
  logic       mapped;
  assign idx = i_paddr[9:2];
  assign mapped = idx inside {IDX_ENABLE_FLAGS, IDX_EDGE_SELECT, IDX_FILTER, IDX_INT_ENABLE,
    IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_TIMER_CONTROL, IDX_TIMER_MODE, IDX_COUNTER_LOW,
    IDX_COUNTER_HIGH, IDX_RESULT_LOW[0], IDX_RESULT_LOW[1], IDX_RESULT_LOW[2],
    IDX_RESULT_HIGH[0], IDX_RESULT_HIGH[1], IDX_RESULT_HIGH[2]};
  always_ff @(posedge i_sys_clk) begin
    pins_d <= {i_capture_pin_2, i_capture_pin_1, i_capture_pin_0};
    if (!i_rst_b || pins_d != {i_capture_pin_2, i_capture_pin_1, i_capture_pin_0}) pin_age <= 4'h0;
    else if (pin_age != 4'hf) pin_age <= pin_age + 4'h1;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) wr_age <= 4'hf;
    else if (i_psel && i_penable && i_pwrite && o_pready) wr_age <= 4'h0;
    else if (wr_age != 4'hf) wr_age <= wr_age + 4'h1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  property p_ready_wait;
    i_psel && !i_penable ##1 i_psel && i_penable |-> !o_pready ##1 o_pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready timing wrong");
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_ready_access;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_rdata_upper;
    o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
  property p_slverr_map;
    o_pready && i_paddr[11:10] == 2'b00 && i_paddr[1:0] == 2'b00 |-> o_pslverr == !mapped;
  endproperty
  a_slverr_map: assert property (p_slverr_map) else $error("pslverr wrong");
  property p_rdata_hold;
    !(i_psel && i_penable) |=> $stable(o_prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("prdata changed idle");
  property p_irq_cause;
    $rose(o_capture_irq) |-> wr_age <= 4'h2 || pin_age <= 4'hc;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_irq_fall;
    $fell(o_capture_irq) |-> wr_age <= 4'h2;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  c_slverr: cover property (o_pready && o_pslverr);
  c_irq_rise: cover property ($rose(o_capture_irq));
  c_irq_fall: cover property ($fell(o_capture_irq));
endmodule
